// [core/phase_event_mask_status.sv]
`timescale 1ns/1ps
`default_nettype none
`include "phase_event_cfg.svh"

module phase_event_mask_status
  import phase_event_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [15:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Phase order detection
  input wire logic [2:0] voltage_rise_i,
  // Neutral mismatch detection
  input wire logic sum_sample_valid_i,
  input wire sample_t phase_current_sum_i,
  input wire sample_t neutral_current_sample_i,
  // Peak periods
  input wire logic current_peak_end_i,
  input wire logic voltage_peak_end_i,
  // Checksum
  input wire logic run_start_i,
  input wire logic checksum_valid_i,
  input wire logic [31:0] checksum_i,
  // Overcurrent and overvoltage detectors, one bit per phase
  input wire logic [2:0] overcurrent_phase_i,
  input wire logic [2:0] overvoltage_phase_i,
  // Dip detection, per phase
  input wire logic [2:0] half_cycle_i,
  input wire sample_t voltage_amplitude_a_i,
  input wire sample_t voltage_amplitude_b_i,
  input wire sample_t voltage_amplitude_c_i,
  // Flags to the main status register
  output logic overcurrent_flag_o,
  output logic overvoltage_flag_o,
  output logic sag_flag_o,
  // Interrupt
  output logic irq_o
);

  // Reset release through two flip-flops
  logic rst_meta_reg, rst_n_reg;
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg <= rst_meta_reg;
    end
  end

  // Register state
  logic [31:0] mask_reg, mask_next;
  logic [31:0] status_reg, status_next;
  sample_t mismatch_threshold_reg, mismatch_threshold_next;
  sample_t dip_threshold_reg, dip_threshold_next;
  logic [7:0] dip_count_reg, dip_count_next;
  logic [2:0] oc_src_reg, oc_src_next;
  logic [2:0] ov_src_reg, ov_src_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic irq_reg, irq_next;
  logic oc_flag_reg, oc_flag_next;
  logic ov_flag_reg, ov_flag_next;
  logic sag_flag_reg, sag_flag_next;

  // Event detection state
  order_state_e order_reg, order_next;
  logic order_err;
  logic [31:0] checksum_ref_reg, checksum_ref_next;
  logic checksum_armed_reg, checksum_armed_next;
  logic mismatch_hit;
  logic [24:0] diff;
  logic [24:0] diff_abs;
  logic [31:0] event_set;
  logic [31:0] clear_bits;
  logic [2:0] dip_state;
  logic [2:0] dip_change;
  logic [15:0] phase_source;
  logic setup, access, wr_take;
  logic mapped;

  // Per-phase dip trackers
  sample_t amplitude [3];
  assign amplitude[0] = voltage_amplitude_a_i;
  assign amplitude[1] = voltage_amplitude_b_i;
  assign amplitude[2] = voltage_amplitude_c_i;

  genvar ph;
  generate
    for (ph = 0; ph < 3; ph++) begin : g_dip
      phase_dip_tracker u_dip (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_reg),
        .half_cycle_i(half_cycle_i[ph]),
        .amplitude_i(amplitude[ph]),
        .dip_threshold_i(dip_threshold_reg),
        .dip_half_cycle_count_i(dip_count_reg),
        .dip_state_o(dip_state[ph]),
        .dip_change_o(dip_change[ph])
      );
    end
  endgenerate

  // Phase order watcher: after an A rise, the next B or C rise decides
  always_comb begin
    order_next = order_reg;
    order_err = 1'b0;
    unique case (order_reg)
      ORDER_IDLE: begin
        if (voltage_rise_i[0]) begin
          order_next = ORDER_AFTER_A;
        end
      end
      ORDER_AFTER_A: begin
        if (voltage_rise_i[2] && !voltage_rise_i[1]) begin
          order_err = 1'b1;
          order_next = voltage_rise_i[0] ? ORDER_AFTER_A : ORDER_IDLE;
        end else if (voltage_rise_i[1]) begin
          order_next = voltage_rise_i[0] ? ORDER_AFTER_A : ORDER_IDLE;
        end
      end
      default: begin
        order_next = ORDER_IDLE;
      end
    endcase
  end

  // Signed difference widened by one bit so it cannot wrap
  assign diff = {phase_current_sum_i[23], phase_current_sum_i} - {neutral_current_sample_i[23], neutral_current_sample_i};
  assign diff_abs = diff[24] ? (25'h000_0000 - diff) : diff;
  assign mismatch_hit = sum_sample_valid_i && (diff_abs > {1'b0, mismatch_threshold_reg});

  // Reference checksum captured in each cycle that the run control is one
  always_comb begin
    checksum_ref_next = checksum_ref_reg;
    checksum_armed_next = checksum_armed_reg;
    if (run_start_i) begin
      checksum_ref_next = checksum_i;
      checksum_armed_next = 1'b1;
    end
  end

  // Event set vector in the mask layout
  always_comb begin
    event_set = 32'h0000_0000;
    event_set[`BIT_PHASE_ORDER_ERR] = order_err;
    event_set[`BIT_NEUTRAL_MISMATCH] = mismatch_hit;
    event_set[`BIT_CURRENT_PEAK] = current_peak_end_i;
    event_set[`BIT_VOLTAGE_PEAK] = voltage_peak_end_i;
    event_set[`BIT_CHECKSUM] = checksum_valid_i && checksum_armed_reg && !run_start_i
                               && (checksum_i != checksum_ref_reg);
  end

  // Phase source register; unused positions are hard zero
  always_comb begin
    phase_source = 16'h0000;
    phase_source[`POS_OVERCURRENT_SRC +: 3] = oc_src_reg;
    phase_source[`POS_OVERVOLTAGE_SRC +: 3] = ov_src_reg;
    phase_source[`POS_DIP_STATE +: 3] = dip_state;
  end

  // APB decode
  assign setup = psel_i && !penable_i;
  assign access = psel_i && penable_i && pready_reg;
  assign wr_take = access && pwrite_i && !pslverr_reg;
  assign clear_bits = (wr_take && paddr_i == `ADDR_EVENT_CLEAR) ? pwdata_i : 32'h0000_0000;

  always_comb begin
    unique case (paddr_i)
      `ADDR_PHASE_EVENT_SOURCE, `ADDR_INT_ENABLE_MASK2, `ADDR_EVENT_STATUS, `ADDR_EVENT_CLEAR,
      `ADDR_MISMATCH_THRESHOLD, `ADDR_DIP_THRESHOLD, `ADDR_DIP_HALF_CYCLE_COUNT: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // Bus answer: ready in the first access cycle, data prepared in setup
  always_comb begin
    pready_next = setup;
    pslverr_next = setup && !mapped;
    prdata_next = prdata_reg;
    if (setup && !pwrite_i) begin
      unique case (paddr_i)
        `ADDR_PHASE_EVENT_SOURCE: prdata_next = {16'h0000, phase_source};
        `ADDR_INT_ENABLE_MASK2: prdata_next = mask_reg;
        `ADDR_EVENT_STATUS: prdata_next = status_reg;
        `ADDR_MISMATCH_THRESHOLD: prdata_next = {8'h00, mismatch_threshold_reg};
        `ADDR_DIP_THRESHOLD: prdata_next = {8'h00, dip_threshold_reg};
        `ADDR_DIP_HALF_CYCLE_COUNT: prdata_next = {24'h00_0000, dip_count_reg};
        default: prdata_next = 32'h0000_0000; // Clear register reads as zero
      endcase
    end
  end

  // Software-written registers; the mask keeps every bit as written
  always_comb begin
    mask_next = mask_reg;
    mismatch_threshold_next = mismatch_threshold_reg;
    dip_threshold_next = dip_threshold_reg;
    dip_count_next = dip_count_reg;
    if (wr_take) begin
      unique case (paddr_i)
        `ADDR_INT_ENABLE_MASK2: mask_next = pwdata_i;
        `ADDR_MISMATCH_THRESHOLD: mismatch_threshold_next = pwdata_i[23:0];
        `ADDR_DIP_THRESHOLD: dip_threshold_next = pwdata_i[23:0];
        `ADDR_DIP_HALF_CYCLE_COUNT: dip_count_next = pwdata_i[7:0];
        default: mask_next = mask_reg;
      endcase
    end
  end

  // Sticky status: a new event wins over a clear in the same cycle
  always_comb begin
    status_next = ((status_reg & ~clear_bits) | event_set) & `EVENT_USED_MASK;
  end

  // Phase sources are replaced by the phases behind each new flag
  always_comb begin
    oc_src_next = oc_src_reg;
    ov_src_next = ov_src_reg;
    oc_flag_next = |overcurrent_phase_i;
    ov_flag_next = |overvoltage_phase_i;
    sag_flag_next = |dip_change;
    if (|overcurrent_phase_i) begin
      oc_src_next = overcurrent_phase_i;
    end
    if (|overvoltage_phase_i) begin
      ov_src_next = overvoltage_phase_i;
    end
  end

  // Interrupt uses the same next-state status so it tracks status_reg exactly
  always_comb begin
    irq_next = |(status_next & mask_next & `EVENT_USED_MASK);
  end

  // All state registers
  always_ff @(posedge core_clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      mask_reg <= `RST_MASK;
      status_reg <= 32'h0000_0000;
      mismatch_threshold_reg <= `RST_MISMATCH_THRESHOLD;
      dip_threshold_reg <= `RST_DIP_THRESHOLD;
      dip_count_reg <= `RST_DIP_HALF_CYCLE_COUNT;
      oc_src_reg <= 3'h0;
      ov_src_reg <= 3'h0;
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      irq_reg <= 1'b0;
      oc_flag_reg <= 1'b0;
      ov_flag_reg <= 1'b0;
      sag_flag_reg <= 1'b0;
      order_reg <= ORDER_IDLE;
      checksum_ref_reg <= 32'h0000_0000;
      checksum_armed_reg <= 1'b0;
    end else begin
      mask_reg <= mask_next;
      status_reg <= status_next;
      mismatch_threshold_reg <= mismatch_threshold_next;
      dip_threshold_reg <= dip_threshold_next;
      dip_count_reg <= dip_count_next;
      oc_src_reg <= oc_src_next;
      ov_src_reg <= ov_src_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      irq_reg <= irq_next;
      oc_flag_reg <= oc_flag_next;
      ov_flag_reg <= ov_flag_next;
      sag_flag_reg <= sag_flag_next;
      order_reg <= order_next;
      checksum_ref_reg <= checksum_ref_next;
      checksum_armed_reg <= checksum_armed_next;
    end
  end

  // Outputs straight from flip-flops
  assign prdata_o = prdata_reg;
  assign pready_o = pready_reg;
  assign pslverr_o = pslverr_reg;
  assign irq_o = irq_reg;
  assign overcurrent_flag_o = oc_flag_reg;
  assign overvoltage_flag_o = ov_flag_reg;
  assign sag_flag_o = sag_flag_reg;

endmodule // phase_event_mask_status

`default_nettype wire

// [core/phase_event_cfg.svh]
`ifndef PHASE_EVENT_CFG_SVH
`define PHASE_EVENT_CFG_SVH

// Register byte addresses
`define ADDR_PHASE_EVENT_SOURCE 16'hE600
`define ADDR_INT_ENABLE_MASK2 16'hE610
`define ADDR_EVENT_STATUS 16'hE614
`define ADDR_EVENT_CLEAR 16'hE618
`define ADDR_MISMATCH_THRESHOLD 16'hE61C
`define ADDR_DIP_THRESHOLD 16'hE620
`define ADDR_DIP_HALF_CYCLE_COUNT 16'hE624

// Event bit positions, shared by mask, status and clear
`define BIT_PHASE_ORDER_ERR 19
`define BIT_NEUTRAL_MISMATCH 20
`define BIT_CURRENT_PEAK 23
`define BIT_VOLTAGE_PEAK 24
`define BIT_CHECKSUM 25
`define EVENT_USED_MASK 32'h0398_0000

// Phase source field positions (A at the low bit)
`define POS_OVERCURRENT_SRC 3
`define POS_OVERVOLTAGE_SRC 9
`define POS_DIP_STATE 12

// Reset values
`define RST_MASK 32'h0000_0000
`define RST_MISMATCH_THRESHOLD 24'h00_0000
`define RST_DIP_THRESHOLD 24'h00_0000
`define RST_DIP_HALF_CYCLE_COUNT 8'h00

`endif

// [core/phase_event_pkg.sv]
package phase_event_pkg;

  // Phase order watcher, one-hot
  typedef enum logic [1:0] {
    ORDER_IDLE = 2'b01,
    ORDER_AFTER_A = 2'b10
  } order_state_e;

  typedef logic [23:0] sample_t;

endpackage

// [core/phase_dip_tracker.sv]
`timescale 1ns/1ps
`default_nettype none
`include "phase_event_cfg.svh"

module phase_dip_tracker
  import phase_event_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Measurement
  input wire logic half_cycle_i,
  input wire sample_t amplitude_i,
  // Settings
  input wire sample_t dip_threshold_i,
  input wire logic [7:0] dip_half_cycle_count_i,
  // Result
  output logic dip_state_o,
  output logic dip_change_o
);

  logic dip_state_reg, dip_state_next;
  logic change_reg, change_next;
  logic [7:0] run_reg, run_next;
  logic below;
  logic [7:0] need;

  // A count of zero is taken as one half cycle, so the state can still move
  assign need = (dip_half_cycle_count_i == 8'h00) ? 8'h01 : dip_half_cycle_count_i;
  assign below = amplitude_i < dip_threshold_i;

  // Count consecutive half cycles that disagree with the present state
  always_comb begin
    dip_state_next = dip_state_reg;
    change_next = 1'b0;
    run_next = run_reg;
    if (half_cycle_i) begin
      if (below == dip_state_reg) begin
        run_next = 8'h00;
      end else if (run_reg + 8'h01 >= need) begin
        dip_state_next = below;
        change_next = 1'b1;
        run_next = 8'h00;
      end else begin
        run_next = run_reg + 8'h01;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dip_state_reg <= 1'b0;
      change_reg <= 1'b0;
      run_reg <= 8'h00;
    end else begin
      dip_state_reg <= dip_state_next;
      change_reg <= change_next;
      run_reg <= run_next;
    end
  end

  assign dip_state_o = dip_state_reg;
  assign dip_change_o = change_reg;

endmodule // phase_dip_tracker

`default_nettype wire

// [testbench/phase_event_mask_status_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
`include "phase_event_cfg.svh"

module phase_event_mask_status_monitor
  import phase_event_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // APB
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [15:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  // Event sources
  input wire logic [2:0] voltage_rise_i,
  input wire logic sum_sample_valid_i,
  input wire sample_t phase_current_sum_i,
  input wire sample_t neutral_current_sample_i,
  input wire logic current_peak_end_i,
  input wire logic voltage_peak_end_i,
  input wire logic [2:0] overcurrent_phase_i,
  input wire logic [2:0] overvoltage_phase_i,
  input wire logic [2:0] half_cycle_i,
  // Results
  input wire logic overcurrent_flag_o,
  input wire logic overvoltage_flag_o,
  input wire logic sag_flag_o,
  input wire logic irq_o
);
  logic [31:0] mask_reg;
  logic [31:0] mask_next;
  logic [23:0] thr_reg;
  logic [23:0] thr_next;
  logic wr_done;
  logic signed [24:0] diff;
  logic [24:0] diff_abs;

  // Shadows follow completed writes, so the checker needs no view inside
  always_comb begin
    wr_done = psel_i && penable_i && pready_o && pwrite_i;
    mask_next = (wr_done && paddr_i == `ADDR_INT_ENABLE_MASK2) ? pwdata_i : mask_reg;
    thr_next = (wr_done && paddr_i == `ADDR_MISMATCH_THRESHOLD) ? pwdata_i[23:0] : thr_reg;
    diff = $signed({phase_current_sum_i[23], phase_current_sum_i})
      - $signed({neutral_current_sample_i[23], neutral_current_sample_i});
    diff_abs = diff[24] ? $unsigned(-diff) : $unsigned(diff);
  end

  // Shadow registers
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mask_reg <= `RST_MASK;
      thr_reg <= `RST_MISMATCH_THRESHOLD;
    end else begin
      mask_reg <= mask_next;
      thr_reg <= thr_next;
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);

  a_order_err_irq: assert property ((mask_reg[19] && voltage_rise_i == 3'b001) ##1 voltage_rise_i == 3'b000
    ##1 voltage_rise_i == 3'b100 |=> irq_o) else $error("phase order error gave no irq");
  a_mismatch_irq: assert property (sum_sample_valid_i && mask_reg[20] && diff_abs > {1'b0, thr_reg}
    |=> irq_o) else $error("neutral mismatch gave no irq");
  a_cur_peak_irq: assert property (current_peak_end_i && mask_reg[23] |=> irq_o)
    else $error("current peak end gave no irq");
  a_volt_peak_irq: assert property (voltage_peak_end_i && mask_reg[24] |=> irq_o)
    else $error("voltage peak end gave no irq");
  a_oc_flag_follows: assert property (overcurrent_flag_o == (|$past(overcurrent_phase_i)))
    else $error("overcurrent flag out of step");
  a_ov_flag_follows: assert property (overvoltage_flag_o == (|$past(overvoltage_phase_i)))
    else $error("overvoltage flag out of step");
  // The dip state moves one edge after the half cycle and the sag flag one edge later still
  a_sag_after_half: assert property (sag_flag_o |-> (|$past(half_cycle_i, 2)))
    else $error("sag flag without half cycle");
  a_src_spare_zero: assert property (psel_i && penable_i && pready_o && !pwrite_i
    && paddr_i == `ADDR_PHASE_EVENT_SOURCE |-> (prdata_o & 32'hFFFF_81C7) == 32'h0000_0000)
    else $error("spare source bits not zero");
  // Irq is built from the mask being written, so the shadow's next value is the one to watch
  a_irq_needs_enable: assert property ((mask_next & `EVENT_USED_MASK) == 32'h0000_0000 |=> !irq_o)
    else $error("irq without enabled event");
endmodule // phase_event_mask_status_monitor

bind phase_event_mask_status phase_event_mask_status_monitor phase_event_mask_status_monitor_i (
  .core_clk_i(core_clk_i), .nrst_i(nrst_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
  .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
  .voltage_rise_i(voltage_rise_i), .sum_sample_valid_i(sum_sample_valid_i),
  .phase_current_sum_i(phase_current_sum_i), .neutral_current_sample_i(neutral_current_sample_i),
  .current_peak_end_i(current_peak_end_i), .voltage_peak_end_i(voltage_peak_end_i),
  .overcurrent_phase_i(overcurrent_phase_i), .overvoltage_phase_i(overvoltage_phase_i),
  .half_cycle_i(half_cycle_i), .overcurrent_flag_o(overcurrent_flag_o),
  .overvoltage_flag_o(overvoltage_flag_o), .sag_flag_o(sag_flag_o), .irq_o(irq_o));
`default_nettype wire

// [testbench/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
`include "phase_event_cfg.svh"

module testbench;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [16:0] ev = 17'h0_0000;
  logic [23:0] sum = 24'h00_0000;
  logic [23:0] neu = 24'h00_0000;
  logic [31:0] chk = 32'h0000_0000;
  logic [23:0] amp_a = 24'h00_0200;
  logic [23:0] amp_c = 24'h00_0200;
  logic [31:0] prdata;
  logic pready, pslverr, oc_flag, ov_flag, sag_flag, irq;
  int err_total = 0;
  int compares = 0;
  int cycles = 0;
  int oc_cnt = 0;
  int ov_cnt = 0;
  int sag_cnt = 0;

  // Event inputs share one vector so a single task can pulse any mix of them
  phase_event_mask_status phase_event_mask_status_i (
    .core_clk_i(clk), .nrst_i(nrst), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .voltage_rise_i(ev[2:0]), .sum_sample_valid_i(ev[14]), .phase_current_sum_i(sum),
    .neutral_current_sample_i(neu), .current_peak_end_i(ev[12]), .voltage_peak_end_i(ev[13]),
    .run_start_i(ev[15]), .checksum_valid_i(ev[16]), .checksum_i(chk), .overcurrent_phase_i(ev[5:3]),
    .overvoltage_phase_i(ev[8:6]), .half_cycle_i(ev[11:9]), .voltage_amplitude_a_i(amp_a),
    .voltage_amplitude_b_i(24'h00_0200), .voltage_amplitude_c_i(amp_c), .overcurrent_flag_o(oc_flag),
    .overvoltage_flag_o(ov_flag), .sag_flag_o(sag_flag), .irq_o(irq));

  // Clock, 40 ns period
  initial begin
    forever #20 clk = ~clk;
  end

  // Flag pulse counts and the hang limit
  always @(posedge clk) begin
    cycles++;
    if (oc_flag === 1'b1) oc_cnt++;
    if (ov_flag === 1'b1) ov_cnt++;
    if (sag_flag === 1'b1) sag_cnt++;
    if (cycles == 5000) begin
      err_total++;
      $display("unexpected at %0t: run hung", $time);
      stop_test();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // One APB transfer; read data is compared only when no error is expected
  task automatic xfer(input logic wr, input logic [15:0] a, input logic [31:0] d, input logic err);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    check({31'h0, pready}, 32'h1, "ready");
    check({31'h0, pslverr}, {31'h0, err}, "slave error");
    if (!wr && !err) check(prdata, d, "read data");
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic fire(input logic [16:0] v);
    @(posedge clk);
    ev <= v;
    @(posedge clk);
    ev <= 17'h0_0000;
  endtask

  // Status shows the one event, irq follows it, and clearing drops both
  task automatic event_seen(input int b);
    xfer(1'b0, `ADDR_EVENT_STATUS, 32'h1 << b, 1'b0);
    check({31'h0, irq}, 32'h1, "irq raised");
    xfer(1'b1, `ADDR_EVENT_CLEAR, 32'h1 << b, 1'b0);
    xfer(1'b0, `ADDR_EVENT_STATUS, 32'h0, 1'b0);
    check({31'h0, irq}, 32'h0, "irq cleared");
  endtask

  task automatic done(input string name);
    $display("test %s finished", name);
  endtask

  task automatic stop_test();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    tick(4);
    nrst <= 1'b1;
    tick(3);
    xfer(1'b0, `ADDR_INT_ENABLE_MASK2, `RST_MASK, 1'b0);
    xfer(1'b0, `ADDR_PHASE_EVENT_SOURCE, 32'h0, 1'b0);
    xfer(1'b1, `ADDR_INT_ENABLE_MASK2, 32'hFFFF_FFFF, 1'b0);
    xfer(1'b0, `ADDR_INT_ENABLE_MASK2, 32'hFFFF_FFFF, 1'b0);
    xfer(1'b1, `ADDR_INT_ENABLE_MASK2, 32'hFC60_0000, 1'b0);
    fire(17'h0_3000);
    tick(2);
    check({31'h0, irq}, 32'h0, "irq, spare mask");
    xfer(1'b1, `ADDR_EVENT_CLEAR, 32'h0180_0000, 1'b0);
    done("mask");
    xfer(1'b1, `ADDR_INT_ENABLE_MASK2, `EVENT_USED_MASK, 1'b0);
    fire(17'h0_1000);
    event_seen(`BIT_CURRENT_PEAK);
    fire(17'h0_2000);
    event_seen(`BIT_VOLTAGE_PEAK);
    fire(17'h0_0001);
    fire(17'h0_0002);
    fire(17'h0_0004);
    xfer(1'b0, `ADDR_EVENT_STATUS, 32'h0, 1'b0);
    fire(17'h0_0001);
    fire(17'h0_0004);
    event_seen(`BIT_PHASE_ORDER_ERR);
    done("order and peaks");
    xfer(1'b1, `ADDR_MISMATCH_THRESHOLD, 32'h0000_0010, 1'b0);
    sum <= 24'h00_0020;
    neu <= 24'h00_0010;
    fire(17'h0_4000);
    xfer(1'b0, `ADDR_EVENT_STATUS, 32'h0, 1'b0);
    neu <= 24'h00_000F;
    fire(17'h0_4000);
    event_seen(`BIT_NEUTRAL_MISMATCH);
    sum <= 24'hFF_FFFB;
    neu <= 24'h00_000C;
    fire(17'h0_4000);
    event_seen(`BIT_NEUTRAL_MISMATCH);
    chk <= 32'h1234_5678;
    fire(17'h0_8000);
    fire(17'h1_0000);
    xfer(1'b0, `ADDR_EVENT_STATUS, 32'h0, 1'b0);
    chk <= 32'h1234_5679;
    fire(17'h1_0000);
    event_seen(`BIT_CHECKSUM);
    done("mismatch and checksum");
    fire(17'h0_0028);
    fire(17'h0_0080);
    xfer(1'b0, `ADDR_PHASE_EVENT_SOURCE, 32'h0000_0428, 1'b0);
    fire(17'h0_0010);
    xfer(1'b0, `ADDR_PHASE_EVENT_SOURCE, 32'h0000_0410, 1'b0);
    xfer(1'b1, `ADDR_DIP_THRESHOLD, 32'h0000_0100, 1'b0);
    xfer(1'b1, `ADDR_DIP_HALF_CYCLE_COUNT, 32'h0000_0002, 1'b0);
    amp_a <= 24'h00_0050;
    fire(17'h0_0200);
    xfer(1'b0, `ADDR_PHASE_EVENT_SOURCE, 32'h0000_0410, 1'b0);
    fire(17'h0_0200);
    xfer(1'b0, `ADDR_PHASE_EVENT_SOURCE, 32'h0000_1410, 1'b0);
    amp_a <= 24'h00_0200;
    amp_c <= 24'h00_0050;
    fire(17'h0_0200);
    fire(17'h0_0200);
    fire(17'h0_0800);
    fire(17'h0_0800);
    xfer(1'b0, `ADDR_PHASE_EVENT_SOURCE, 32'h0000_4410, 1'b0);
    xfer(1'b1, `ADDR_PHASE_EVENT_SOURCE, 32'hFFFF_FFFF, 1'b0);
    xfer(1'b0, `ADDR_PHASE_EVENT_SOURCE, 32'h0000_4410, 1'b0);
    xfer(1'b1, 16'hE6F0, 32'hFFFF_FFFF, 1'b1);
    xfer(1'b0, 16'hE6F0, 32'h0, 1'b1);
    check(oc_cnt, 32'd2, "overcurrent pulses");
    check(ov_cnt, 32'd1, "overvoltage pulses");
    check(sag_cnt, 32'd3, "sag pulses");
    done("sources and dips");
    stop_test();
  end
endmodule // testbench
`default_nettype wire
